/* File: inc/dpram_pkg.sv */
// shared constants for the dual-port ram port pipeline
package dpram_pkg;
  // pin layout of each port
  localparam int          ADDR_W     = 14;
  localparam int          DATA_W     = 18;
  localparam int          A_WORD_LSB = 3;
  localparam int          A_WORD_W   = 11;
  localparam int          B_WORD_LSB = 4;
  localparam int          B_WORD_W   = 10;
  localparam int          BYTE_W     = 8;
  localparam int          B_HI_LSB   = 9;
  localparam int          MEM_BYTES  = 2048;
  localparam logic [2:0]  BANK_MARK  = 3'h0;
  // output values
  localparam logic [17:0] RST_VAL    = 18'h00000;
  localparam logic [17:0] ONES       = 18'h3ffff;
  // register map
  localparam int          AXI_AW     = 5;
  localparam logic [4:0]  OFF_CTRL   = 5'h00;
  localparam logic [4:0]  OFF_STAT   = 5'h04;
  localparam logic [4:0]  OFF_ADDR_A = 5'h08;
  localparam logic [4:0]  OFF_ADDR_B = 5'h0c;
  // control fields
  localparam int          CTRL_W     = 4;
  localparam int          CTRL_OR_A  = 0;
  localparam int          CTRL_OR_B  = 1;
  localparam int          CTRL_ASYNC = 2;
  localparam int          CTRL_GDIS  = 3;
  localparam logic [3:0]  CTRL_RST   = 4'h3;
  // bus responses
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
endpackage

/* File: verilog/port_out_stage.sv */
// output latch, optional output register and reset handling of one port
`timescale 1ns/1ns
module port_out_stage
  import dpram_pkg::*;
(
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        port_rst,
  input  wire logic                        async_mode,
  input  wire logic                        global_rst,
  input  wire logic                        or_enable,
  input  wire logic                        or_ce,
  input  wire logic                        load,
  input  wire logic [dpram_pkg::DATA_W-1:0] load_data,
  input  wire logic                        logic_en,
  output logic      [dpram_pkg::DATA_W-1:0] dout,
  output logic                             rst_active
);
  import dpram_pkg::*;

  logic [DATA_W-1:0] latch_reg;
  logic [DATA_W-1:0] or_reg;
  logic              rst_now;
  logic              force_rst;

  // either reset source clears the stage
  assign rst_now    = port_rst | global_rst;
  // sync mode waits for the edge; async and global act at once
  assign force_rst  = global_rst | (async_mode & port_rst);
  assign rst_active = rst_now;

  // latch: port reset sampled on the clock edge in either mode
  always_ff @(posedge aclk) begin
    if (!aresetn || rst_now) begin
      latch_reg <= RST_VAL;
    end else if (load) begin
      latch_reg <= load_data;
    end
  end

  // output register, stalls while its enable is low
  always_ff @(posedge aclk) begin
    if (!aresetn || rst_now) begin
      or_reg <= RST_VAL;
    end else if (or_enable && or_ce) begin
      or_reg <= latch_reg;
    end
  end

  // output select; forcing is combinational so reset is seen without an edge
  always_comb begin
    if (!logic_en) begin
      dout = ONES;
    end else if (force_rst) begin
      dout = RST_VAL;
    end else if (or_enable) begin
      dout = or_reg;
    end else begin
      dout = latch_reg;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rst_clears_out_a: assert property (port_rst ##1 (logic_en && !global_rst) |-> dout == RST_VAL)
    else $error("port reset did not clear output");
  async_now_a: assert property (logic_en && async_mode && port_rst |-> dout == RST_VAL)
    else $error("async reset not immediate");
  ones_at_config_a: assert property (!logic_en |-> dout == ONES)
    else $error("output not all ones before enable");
  or_stall_a: assert property (or_enable && !or_ce && !rst_now |=> $stable(or_reg))
    else $error("output register moved while stalled");
  or_load_a: assert property (or_enable && or_ce && !rst_now |=> or_reg == $past(latch_reg))
    else $error("output register missed a load");
  bypass_path_a: assert property (logic_en && !or_enable && !force_rst |-> dout == latch_reg)
    else $error("bypass does not show the latch");
  release_edge_a: assert property (async_mode && $fell(port_rst) && !global_rst |-> latch_reg == RST_VAL)
    else $error("latch resumed before a clock edge");
endmodule

/* File: verilog/dpram_ports.sv */
// dual-port ram with input stage, address freeze, output stages and register slave
`timescale 1ns/1ns
module dpram_ports
  import dpram_pkg::*;
(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // port a
  input  wire logic                         ce_a,
  input  wire logic                         we_a,
  input  wire logic [dpram_pkg::ADDR_W-1:0] addr_a,
  input  wire logic                         addr_hold_a,
  input  wire logic [2:0]                   bank_select_a,
  input  wire logic [dpram_pkg::DATA_W-1:0] din_a,
  input  wire logic                         or_ce_a,
  input  wire logic                         rst_a,
  output logic      [dpram_pkg::DATA_W-1:0] dout_a,
  // port b
  input  wire logic                         ce_b,
  input  wire logic                         we_b,
  input  wire logic [dpram_pkg::ADDR_W-1:0] addr_b,
  input  wire logic                         addr_hold_b,
  input  wire logic [2:0]                   bank_select_b,
  input  wire logic [dpram_pkg::DATA_W-1:0] din_b,
  input  wire logic                         or_ce_b,
  input  wire logic                         rst_b,
  output logic      [dpram_pkg::DATA_W-1:0] dout_b,
  // chip-wide controls
  input  wire logic                         global_reset_n,
  input  wire logic                         global_logic_enable,
  // register slave
  input  wire logic [dpram_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic      [1:0]                   s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [dpram_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic      [31:0]                  s_axi_rdata,
  output logic      [1:0]                   s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready
);
  import dpram_pkg::*;

  logic [BYTE_W-1:0]   mem [0:MEM_BYTES-1];
  // input stage
  logic [A_WORD_W-1:0] cap_addr_a;
  logic [A_WORD_W-1:0] addr_next_a;
  logic [BYTE_W-1:0]   cap_din_a;
  logic                cap_we_a;
  logic                cap_en_a;
  logic [B_WORD_W-1:0] cap_addr_b;
  logic [B_WORD_W-1:0] addr_next_b;
  logic [15:0]         cap_din_b;
  logic [1:0]          cap_be_b;
  logic                cap_we_b;
  logic                cap_en_b;
  // array access
  logic [10:0]         lo_idx_b;
  logic [10:0]         hi_idx_b;
  logic [DATA_W-1:0]   load_data_a;
  logic [DATA_W-1:0]   load_data_b;
  logic [BYTE_W-1:0]   lo_b;
  logic [BYTE_W-1:0]   hi_b;
  logic                global_rst;
  logic                rst_act_a;
  logic                rst_act_b;
  // register slave
  logic [CTRL_W-1:0]   ctrl_reg;
  logic                aw_held_reg;
  logic [AXI_AW-1:0]   aw_addr_reg;
  logic                w_held_reg;
  logic [31:0]         w_data_reg;
  logic [3:0]          w_strb_reg;
  logic                wr_fire;

  // decode used by both read and write paths
  function automatic logic reg_known(input logic [AXI_AW-1:0] a);
    reg_known = (a == OFF_CTRL) || (a == OFF_STAT) || (a == OFF_ADDR_A) || (a == OFF_ADDR_B);
  endfunction

  // freeze keeps the registered address; new word address pins are ignored, but port b byte enables on addr_b[1:0] are still sampled
  assign addr_next_a = addr_hold_a ? cap_addr_a : addr_a[ADDR_W-1:A_WORD_LSB];
  assign addr_next_b = addr_hold_b ? cap_addr_b : addr_b[ADDR_W-1:B_WORD_LSB];

  // port a input stage, always in the path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_addr_a <= '0;
      cap_din_a  <= '0;
      cap_we_a   <= 1'b0;
      cap_en_a   <= 1'b0;
    end else begin
      cap_addr_a <= addr_next_a;
      cap_din_a  <= din_a[BYTE_W-1:0];
      cap_we_a   <= we_a;
      cap_en_a   <= ce_a && (bank_select_a == BANK_MARK);
    end
  end

  // port b input stage; byte enables ride on the low address pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_addr_b <= '0;
      cap_din_b  <= '0;
      cap_be_b   <= '0;
      cap_we_b   <= 1'b0;
      cap_en_b   <= 1'b0;
    end else begin
      cap_addr_b <= addr_next_b;
      cap_din_b  <= {din_b[B_HI_LSB+BYTE_W-1:B_HI_LSB], din_b[BYTE_W-1:0]};
      cap_be_b   <= addr_b[1:0];
      cap_we_b   <= we_b;
      cap_en_b   <= ce_b && (bank_select_b == BANK_MARK);
    end
  end

  // port b word maps onto two consecutive bytes
  assign lo_idx_b = {cap_addr_b, 1'b0};
  assign hi_idx_b = {cap_addr_b, 1'b1};

  // array writes; same-address collisions are the user's to avoid
  always_ff @(posedge aclk) begin
    if (cap_en_a && cap_we_a) begin
      mem[cap_addr_a] <= cap_din_a;
    end
    if (cap_en_b && cap_we_b && cap_be_b[0]) begin
      mem[lo_idx_b] <= cap_din_b[BYTE_W-1:0];
    end
    if (cap_en_b && cap_we_b && cap_be_b[1]) begin
      mem[hi_idx_b] <= cap_din_b[15:BYTE_W];
    end
  end

  // pass-through: written bytes go to the latch, unwritten ones read back
  assign lo_b = (cap_we_b && cap_be_b[0]) ? cap_din_b[BYTE_W-1:0] : mem[lo_idx_b];
  assign hi_b = (cap_we_b && cap_be_b[1]) ? cap_din_b[15:BYTE_W] : mem[hi_idx_b];
  assign load_data_a = {10'h000, (cap_we_a ? cap_din_a : mem[cap_addr_a])};
  assign load_data_b = {1'b0, hi_b, 1'b0, lo_b};

  // global reset has effect unless configuration disables it
  assign global_rst = !global_reset_n && !ctrl_reg[CTRL_GDIS];

  // one reset-style bit drives both ports
  port_out_stage u_out_a (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .port_rst   (rst_a),
    .async_mode (ctrl_reg[CTRL_ASYNC]),
    .global_rst (global_rst),
    .or_enable  (ctrl_reg[CTRL_OR_A]),
    .or_ce      (or_ce_a),
    .load       (cap_en_a),
    .load_data  (load_data_a),
    .logic_en   (global_logic_enable),
    .dout       (dout_a),
    .rst_active (rst_act_a)
  );

  port_out_stage u_out_b (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .port_rst   (rst_b),
    .async_mode (ctrl_reg[CTRL_ASYNC]),
    .global_rst (global_rst),
    .or_enable  (ctrl_reg[CTRL_OR_B]),
    .or_ce      (or_ce_b),
    .load       (cap_en_b),
    .load_data  (load_data_b),
    .logic_en   (global_logic_enable),
    .dout       (dout_b),
    .rst_active (rst_act_b)
  );

  // write channel: address and data accepted in either order
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_fire       = aw_held_reg && w_held_reg;

  // hold address and data until both are here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= reg_known(aw_addr_reg) ? RESP_OKAY : RESP_SLV;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // configuration; resets to both output registers on, sync reset style
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_fire && aw_addr_reg == OFF_CTRL && w_strb_reg[0]) begin
      ctrl_reg <= w_data_reg[CTRL_W-1:0];
    end
  end

  // read channel, one word answered the cycle after the address
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLV;
      case (s_axi_araddr)
        OFF_CTRL:   s_axi_rdata <= {28'h0000000, ctrl_reg};
        OFF_STAT:   s_axi_rdata <= {28'h0000000, global_rst, rst_act_b, rst_act_a, global_logic_enable};
        OFF_ADDR_A: s_axi_rdata <= {21'h000000, cap_addr_a};
        OFF_ADDR_B: s_axi_rdata <= {22'h000000, cap_addr_b};
        default:    s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  input_stage_a: assert property (!addr_hold_a |=> cap_addr_a == $past(addr_a[ADDR_W-1:A_WORD_LSB]))
    else $error("port a address not registered");
  freeze_hold_a: assert property (addr_hold_b |=> cap_addr_b == $past(cap_addr_b))
    else $error("port b address moved while frozen");
  latency_two_a: assert property (
      ce_a && !we_a && bank_select_a == BANK_MARK && !addr_hold_a && ctrl_reg[CTRL_OR_A]
      ##1 (or_ce_a && !rst_a && global_logic_enable && !global_rst)[*2]
      ##1 (!rst_a && global_logic_enable && !global_rst && $stable(ctrl_reg))
      |-> dout_a == $past(load_data_a, 2))
    else $error("registered read not two cycles after capture");
endmodule

/* File: tb/ram_user_model.sv */
// fabric-side model: packs user words and bytes onto the ram port pins
`timescale 1ns/1ns
module ram_user_model
  import dpram_pkg::*;
(
  input  wire logic [10:0]                  word_a,
  input  wire logic [7:0]                   byte_a,
  input  wire logic [9:0]                   word_b,
  input  wire logic [1:0]                   bweb,
  input  wire logic [15:0]                  data_b,
  output logic      [dpram_pkg::ADDR_W-1:0] addr_a,
  output logic      [dpram_pkg::ADDR_W-1:0] addr_b,
  output logic      [dpram_pkg::DATA_W-1:0] din_a,
  output logic      [dpram_pkg::DATA_W-1:0] din_b,
  output logic      [2:0]                   bank_select_a,
  output logic      [2:0]                   bank_select_b
);
  // narrow port: word on the top pins, low three parked high
  assign addr_a = {word_a, 3'h7};
  // wide port: byte enables ride on the two lowest address pins
  assign addr_b = {word_b, 2'h3, bweb};
  // spare data pins held low, never left floating
  assign din_a = {10'h000, byte_a};
  assign din_b = {1'h0, data_b[15:8], 1'h0, data_b[7:0]};
  // single block, no depth cascading
  assign bank_select_a = BANK_MARK;
  assign bank_select_b = BANK_MARK;
endmodule

/* File: tb/tb_dpram_ports.sv */
// self-checking bench for the dual-port ram port pipeline
`timescale 1ns/1ns
module tb_dpram_ports;
  import dpram_pkg::*;
  logic              aclk, aresetn, ce_a, we_a, addr_hold_a, or_ce_a, rst_a;
  logic              ce_b, we_b, addr_hold_b, or_ce_b, rst_b, global_reset_n, global_logic_enable;
  logic [10:0]       word_a;
  logic [7:0]        byte_a;
  logic [9:0]        word_b;
  logic [1:0]        bweb, bresp, rresp, rs;
  logic [15:0]       data_b;
  logic [ADDR_W-1:0] addr_a, addr_b;
  logic [DATA_W-1:0] din_a, din_b, dout_a, dout_b, prev_a, prev_b;
  logic [2:0]        bank_select_a, bank_select_b;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic              awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0]       wdata, rdata, rd;
  int                fail_count, tests_run;

  ram_user_model i_ram_user_model (.word_a(word_a), .byte_a(byte_a), .word_b(word_b), .bweb(bweb),
    .data_b(data_b), .addr_a(addr_a), .addr_b(addr_b), .din_a(din_a), .din_b(din_b),
    .bank_select_a(bank_select_a), .bank_select_b(bank_select_b));
  // one shared clock; both ports registered with pass-through writes
  dpram_ports i_dpram_ports (.aclk(aclk), .aresetn(aresetn), .ce_a(ce_a), .we_a(we_a), .addr_a(addr_a),
    .addr_hold_a(addr_hold_a), .bank_select_a(bank_select_a), .din_a(din_a), .or_ce_a(or_ce_a),
    .rst_a(rst_a), .dout_a(dout_a), .ce_b(ce_b), .we_b(we_b), .addr_b(addr_b), .addr_hold_b(addr_hold_b),
    .bank_select_b(bank_select_b), .din_b(din_b), .or_ce_b(or_ce_b), .rst_b(rst_b), .dout_b(dout_b),
    .global_reset_n(global_reset_n), .global_logic_enable(global_logic_enable),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  // 50 ns period
  initial begin
    aclk = 1'h0;
    forever #25 aclk = ~aclk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_d(input string n, input logic [17:0] e, input logic [17:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_w(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // bounded wait; a dead slave ends the run instead of hanging it
  task automatic bus_dead(input logic done);
    if (!done) begin
      fail_count++;
      $display("ERROR bus answer expected 1 seen 0");
      finish_test();
    end
  endtask

  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) begin
        r = bresp;
        done = 1'h1;
      end
    end
    bready <= 1'h0;
    bus_dead(done);
  endtask

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        done = 1'h1;
      end
    end
    rready <= 1'h0;
    bus_dead(done);
  endtask

  // one-cycle port access; returns at the capture edge
  task automatic acc(input logic b, input logic wr, input logic [10:0] w, input logic [1:0] be,
                     input logic [15:0] d);
    @(posedge aclk);
    if (b) begin
      ce_b <= 1'h1;
      we_b <= wr;
      word_b <= w[9:0];
      bweb <= be;
      data_b <= d;
    end else begin
      ce_a <= 1'h1;
      we_a <= wr;
      word_a <= w;
      byte_a <= d[7:0];
    end
    @(posedge aclk);
    {ce_a, we_a, ce_b, we_b} <= 4'h0;
  endtask

  // old value one edge before the latency runs out, new value exactly on it
  task automatic see(input logic b, input int lat, input logic [17:0] e);
    repeat (lat - 1) @(posedge aclk);
    #1;
    chk_d(b ? "dout_b early" : "dout_a early", b ? prev_b : prev_a, b ? dout_b : dout_a);
    @(posedge aclk);
    #1;
    chk_d(b ? "dout_b" : "dout_a", e, b ? dout_b : dout_a);
    if (b) prev_b = e;
    else prev_a = e;
  endtask

  initial begin
    {ce_a, we_a, addr_hold_a, rst_a, ce_b, we_b, addr_hold_b, rst_b} = 8'h00;
    {or_ce_a, or_ce_b, global_reset_n, global_logic_enable, aresetn} = 5'h1c;
    {word_a, byte_a, word_b, bweb, data_b} = '0;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    fail_count = 0;
    tests_run = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    #1;
    chk_d("dout_a boot", ONES, dout_a);
    axi_rd(OFF_CTRL, rd, rs);
    chk_w("ctrl", {28'h0, CTRL_RST}, rd);
    global_logic_enable <= 1'h1;
    axi_wr(OFF_STAT, 32'h0, rs);
    chk_w("stat wr resp", {30'h0, RESP_OKAY}, {30'h0, rs});
    axi_rd(OFF_STAT, rd, rs);
    chk_w("stat", 32'h1, rd);
    axi_rd(5'h10, rd, rs);
    chk_w("unmapped resp", {30'h0, RESP_SLV}, {30'h0, rs});
    chk_w("unmapped data", 32'h0, rd);
    chk_d("dout_a live", RST_VAL, dout_a);
    {prev_a, prev_b} = {RST_VAL, RST_VAL};
    $display("test registers done");
    acc(0, 1, 11'h00a, 2'h0, 16'h0011);
    see(0, 2, 18'h00011);
    acc(0, 1, 11'h00b, 2'h0, 16'h0022);
    see(0, 2, 18'h00022);
    acc(1, 0, 11'h005, 2'h0, 16'h0000);
    see(1, 2, 18'h04411);
    acc(1, 1, 11'h005, 2'h1, 16'h3399);
    see(1, 2, 18'h04499);
    acc(1, 1, 11'h005, 2'h2, 16'h7700);
    see(1, 2, 18'h0ee99);
    acc(0, 0, 11'h00b, 2'h0, 16'h0000);
    see(0, 2, 18'h00077);
    $display("test data paths done");
    or_ce_a <= 1'h0;
    acc(0, 0, 11'h00a, 2'h0, 16'h0000);
    repeat (3) @(posedge aclk);
    #1;
    chk_d("dout_a stalled", 18'h00077, dout_a);
    @(posedge aclk) or_ce_a <= 1'h1;
    see(0, 1, 18'h00099);
    $display("test stall done");
    // port reset driven from the port clock
    @(posedge aclk) rst_a <= 1'h1;
    #1;
    chk_d("dout_a before sample", 18'h00099, dout_a);
    @(posedge aclk) rst_a <= 1'h0;
    #1;
    chk_d("dout_a sync reset", RST_VAL, dout_a);
    chk_d("dout_b untouched", 18'h0ee99, dout_b);
    prev_a = RST_VAL;
    acc(0, 0, 11'h00b, 2'h0, 16'h0000);
    see(0, 2, 18'h00077);
    $display("test sync reset done");
    axi_wr(OFF_CTRL, 32'h7, rs);
    @(posedge aclk) rst_b <= 1'h1;
    #1;
    chk_d("dout_b async reset", RST_VAL, dout_b);
    axi_rd(OFF_STAT, rd, rs);
    chk_w("stat port b reset", 32'h5, rd);
    @(posedge aclk) rst_b <= 1'h0;
    repeat (2) @(posedge aclk);
    #1;
    chk_d("dout_b after release", RST_VAL, dout_b);
    prev_b = RST_VAL;
    acc(1, 0, 11'h005, 2'h0, 16'h0000);
    see(1, 2, 18'h0ee99);
    @(posedge aclk) rst_a <= 1'h1;
    #1;
    chk_d("dout_a async reset", RST_VAL, dout_a);
    @(posedge aclk) rst_a <= 1'h0;
    prev_a = RST_VAL;
    $display("test async reset done");
    axi_wr(OFF_CTRL, 32'h3, rs);
    @(posedge aclk) global_reset_n <= 1'h0;
    #1;
    chk_d("dout_b global reset", RST_VAL, dout_b);
    axi_rd(OFF_STAT, rd, rs);
    chk_w("stat global reset", 32'hf, rd);
    @(posedge aclk) global_reset_n <= 1'h1;
    prev_b = RST_VAL;
    acc(1, 0, 11'h005, 2'h0, 16'h0000);
    see(1, 2, 18'h0ee99);
    axi_wr(OFF_CTRL, 32'hb, rs);
    @(posedge aclk) global_reset_n <= 1'h0;
    repeat (2) @(posedge aclk);
    #1;
    chk_d("dout_b global masked", 18'h0ee99, dout_b);
    @(posedge aclk) global_reset_n <= 1'h1;
    $display("test global reset done");
    // bypass: latch straight out, enable ignored
    axi_wr(OFF_CTRL, 32'h0, rs);
    or_ce_a <= 1'h0;
    acc(0, 0, 11'h00b, 2'h0, 16'h0000);
    see(0, 1, 18'h00077);
    acc(0, 0, 11'h00a, 2'h0, 16'h0000);
    see(0, 1, 18'h00099);
    addr_hold_a <= 1'h1;
    addr_hold_b <= 1'h1;
    word_b <= 10'h001;
    acc(0, 0, 11'h00b, 2'h0, 16'h0000);
    see(0, 1, 18'h00099);
    axi_rd(OFF_ADDR_A, rd, rs);
    chk_w("frozen address", 32'h00a, rd);
    axi_rd(OFF_ADDR_B, rd, rs);
    chk_w("frozen address b", 32'h005, rd);
    addr_hold_a <= 1'h0;
    addr_hold_b <= 1'h0;
    $display("test bypass and freeze done");
    @(posedge aclk) global_logic_enable <= 1'h0;
    #1;
    chk_d("dout_a disabled", ONES, dout_a);
    chk_d("dout_b disabled", ONES, dout_b);
    $display("test logic enable done");
    finish_test();
  end
endmodule
